// [logic/gpiol_top.sv]
// gpiol_top: eight-channel gpio port with per-channel settings, latched inputs
// and a shared open-drain interrupt request, behind an axi4-lite slave.
// assumes one 100 MHz clock, synchronous reset, and asynchronous terminal levels.
//
// What this block does
// (RULE1) status register, one bit per channel
// (RULE2) direction bit: 0 output, 1 input
// (RULE3) pull select bit: 0 down, 1 up
// (RULE4) pull enable bit: 0 off, 1 on
// (RULE5) open-drain outputs force the pull off
// (RULE6) invert bit flips the value read
// (RULE7) capture bit: 0 transparent, 1 latched
// (RULE8) transparent: live value, change raises status
// (RULE9) transparent: input read clears status
// (RULE10) transparent: reverting change withdraws status
// (RULE11) latched: change raises status, captures level
// (RULE12) latched: input read clears status
// (RULE13) latched revert: stays pending, captured then original
// (RULE14) every input read acts on all channels
// (RULE15) mode switch selects live or captured view
// (RULE16) one port-wide push-pull or open-drain setting
// (RULE17) host sets output type before directions
// (RULE18) mask bit 1 suppresses channel interrupt
// (RULE19) request held while any status remains
// (RULE20) setting writes carry all eight channels
// (RULE21) request line shareable among several boards
// (RULE22) defined reset configuration of the port
// (RULE23) output latch writable while channel is input
// (RULE24) output channels read their terminal level
// (RULE25) active-low open-drain request, wired-or capable
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps

module gpiol_top
    import gpiol_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // register bus
    input wire gpiol_axi_req_t axi_req_i,
    output gpiol_axi_rsp_t axi_rsp_o,
    // channel terminals
    input wire logic [CH_N-1:0] gpio_in_i,
    output logic [CH_N-1:0] gpio_out_o,
    output logic [CH_N-1:0] gpio_oe_o,
    output logic [CH_N-1:0] pull_en_o,
    output logic [CH_N-1:0] pull_up_o,
    // shared interrupt request
    output logic irq_n_o,
    output logic irq_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // state of the whole block in one record
    typedef struct packed {
        gpiol_cfg_t cfg;            // software settings
        logic [CH_N-1:0] sync1;     // first synchroniser stage
        logic [CH_N-1:0] sync2;     // second stage
        logic [CH_N-1:0] sync3;     // third stage
        logic [CH_N-1:0] pin_lvl;   // filtered terminal level
        logic [CH_N-1:0] ref_lvl;   // level shown by the last input read
        logic [CH_N-1:0] cap;       // captured level of latched channels
        logic [CH_N-1:0] pend;      // latched change not yet read
        logic [CH_N-1:0] status;    // interrupt status vector
        logic [CH_N-1:0] oe;        // terminal drive enables
        logic [CH_N-1:0] pull_en;   // effective pull enables
        logic irq;                  // request asserted
        gpiol_rd_t rd_st;           // read channel state
        logic aw_full;              // write address held
        logic w_full;               // write data held
        logic [AXI_AW-1:0] awaddr;  // held write address
        logic [CH_N-1:0] wbyte;     // held channel byte
        logic wlane;                // held strobe of that byte
        gpiol_axi_rsp_t rsp;        // bus answer
    } gpiol_state_t;

    gpiol_state_t st_r;             // registered state
    gpiol_state_t st_nxt;           // next state
    logic [CH_N-1:0] seen;          // filtered level after polarity
    logic [CH_N-1:0] in_val;        // value an input read returns
    logic [CH_N-1:0] cap_evt;       // latched channels capturing now
    logic [CH_N-1:0] lvl_agree;     // stages two and three agree
    logic [AXI_AW-1:0] waddr_w;     // word-aligned write address
    logic [AXI_AW-1:0] raddr_w;     // word-aligned read address
    logic wr_go;                    // write executes this cycle
    logic rd_go;                    // read accepted this cycle
    logic rd_input;                 // accepted read targets the input register

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // three-stage synchroniser; only the second stage reads the first
        st_nxt.sync1 = gpio_in_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        // a level counts once the second and third stages agree
        lvl_agree = ~(st_r.sync2 ^ st_r.sync3);
        st_nxt.pin_lvl = (st_r.sync3 & lvl_agree) | (st_r.pin_lvl & ~lvl_agree);

        // the terminal level is read for outputs too, never the latch
        seen = st_r.pin_lvl ^ st_r.cfg.invert; // RULE6 RULE24
        // pending latched channels show the capture, others the live level
        in_val = (st_r.cfg.latch & st_r.pend & st_r.cap)
            | (~(st_r.cfg.latch & st_r.pend) & seen); // RULE8 RULE13 RULE15

        // a latched channel captures the first change away from its reference
        cap_evt = st_r.cfg.latch & ~st_r.pend & (seen ^ st_r.ref_lvl); // RULE11
        st_nxt.cap = (st_r.cap & ~cap_evt) | (seen & cap_evt); // RULE11
        // leaving latched mode drops the capture so reads go live again
        st_nxt.pend = (st_r.pend | cap_evt) & st_r.cfg.latch; // RULE13 RULE15

        ////////////////////////////////////////////////////////////////////
        // write channel: address and data are taken in either order
        waddr_w = {st_r.awaddr[AXI_AW-1:IDX_LSB], {IDX_LSB{1'b0}}};
        wr_go = st_r.aw_full && st_r.w_full && !st_r.rsp.bvalid;
        if (axi_req_i.awvalid && st_r.rsp.awready)
        begin
            st_nxt.aw_full = 1'b1;
            st_nxt.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && st_r.rsp.wready)
        begin
            st_nxt.w_full = 1'b1;
            st_nxt.wbyte = axi_req_i.wdata[CH_N-1:0];
            st_nxt.wlane = axi_req_i.wstrb[BYTE0];
        end
        // response retires once the master takes it
        if (st_r.rsp.bvalid && axi_req_i.bready)
        begin
            st_nxt.rsp.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = RESP_OKAY;
            // every setting write updates all eight channels at once
            unique case (waddr_w)
                ADDR_OUTPUT:
                begin
                    // stored even for inputs, so it is ready on turn-around
                    if (st_r.wlane) st_nxt.cfg.out = st_r.wbyte; // RULE23
                end
                ADDR_DIR:
                begin
                    if (st_r.wlane) st_nxt.cfg.dir = st_r.wbyte; // RULE2 RULE20
                end
                ADDR_PULL_SEL:
                begin
                    if (st_r.wlane) st_nxt.cfg.pull_sel = st_r.wbyte; // RULE3
                end
                ADDR_PULL_EN:
                begin
                    if (st_r.wlane) st_nxt.cfg.pull_en = st_r.wbyte; // RULE4
                end
                ADDR_INVERT:
                begin
                    if (st_r.wlane) st_nxt.cfg.invert = st_r.wbyte; // RULE6
                end
                ADDR_LATCH:
                begin
                    if (st_r.wlane) st_nxt.cfg.latch = st_r.wbyte; // RULE7
                end
                ADDR_OTYPE:
                begin
                    // one bit for the whole port, other bits ignored
                    if (st_r.wlane) st_nxt.cfg.otype = st_r.wbyte[OTYPE_BIT]; // RULE16
                end
                ADDR_MASK:
                begin
                    if (st_r.wlane) st_nxt.cfg.mask = st_r.wbyte; // RULE18
                end
                ADDR_INPUT, ADDR_STATUS:
                begin
                    // read-only registers: write accepted and dropped
                    st_nxt.rsp.bresp = RESP_OKAY;
                end
                default:
                begin
                    // unmapped word
                    st_nxt.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        // a slot is offered only while it is empty and no answer waits
        st_nxt.rsp.awready = !st_nxt.aw_full && !st_nxt.rsp.bvalid;
        st_nxt.rsp.wready = !st_nxt.w_full && !st_nxt.rsp.bvalid;

        ////////////////////////////////////////////////////////////////////
        // read channel: one read at a time, answered the cycle after it is taken
        raddr_w = {axi_req_i.araddr[AXI_AW-1:IDX_LSB], {IDX_LSB{1'b0}}};
        rd_go = 1'b0;
        rd_input = 1'b0;
        unique case (st_r.rd_st)
            RD_IDLE:
            begin
                if (axi_req_i.arvalid && st_r.rsp.arready)
                begin
                    rd_go = 1'b1;
                    st_nxt.rd_st = RD_BUSY;
                    st_nxt.rsp.arready = 1'b0;
                    st_nxt.rsp.rvalid = 1'b1;
                    st_nxt.rsp.rresp = RESP_OKAY;
                    st_nxt.rsp.rdata = '0;
                    unique case (raddr_w)
                        ADDR_INPUT:
                        begin
                            // the whole register is read, so every channel is
                            // released together
                            rd_input = 1'b1;
                            st_nxt.rsp.rdata[CH_N-1:0] = in_val; // RULE14
                            st_nxt.ref_lvl = in_val; // RULE9 RULE10
                            st_nxt.pend = '0; // RULE12 RULE13
                        end
                        ADDR_OUTPUT: st_nxt.rsp.rdata[CH_N-1:0] = st_r.cfg.out;
                        ADDR_DIR: st_nxt.rsp.rdata[CH_N-1:0] = st_r.cfg.dir;
                        ADDR_PULL_SEL: st_nxt.rsp.rdata[CH_N-1:0] = st_r.cfg.pull_sel;
                        ADDR_PULL_EN: st_nxt.rsp.rdata[CH_N-1:0] = st_r.cfg.pull_en;
                        ADDR_INVERT: st_nxt.rsp.rdata[CH_N-1:0] = st_r.cfg.invert;
                        ADDR_LATCH: st_nxt.rsp.rdata[CH_N-1:0] = st_r.cfg.latch;
                        ADDR_OTYPE: st_nxt.rsp.rdata[OTYPE_BIT] = st_r.cfg.otype;
                        ADDR_MASK: st_nxt.rsp.rdata[CH_N-1:0] = st_r.cfg.mask;
                        ADDR_STATUS: st_nxt.rsp.rdata[CH_N-1:0] = st_r.status; // RULE1
                        default: st_nxt.rsp.rresp = RESP_SLVERR;
                    endcase
                end
            end
            RD_BUSY:
            begin
                // answer stands until the master takes it
                if (axi_req_i.rready)
                begin
                    st_nxt.rd_st = RD_IDLE;
                    st_nxt.rsp.rvalid = 1'b0;
                    st_nxt.rsp.arready = 1'b1;
                end
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // interrupt status from the next settings, so a mask acts at once;
        // a change after a read sees the new reference and is raised again
        st_nxt.status = ~st_nxt.cfg.mask
            & ((st_nxt.cfg.latch & st_nxt.pend)
            | (~st_nxt.cfg.latch & (seen ^ st_nxt.ref_lvl))); // RULE8 RULE10 RULE18
        // held while any channel is left uncleared
        st_nxt.irq = |st_nxt.status; // RULE19

        // open-drain outputs only pull low; push-pull outputs drive both ways
        st_nxt.oe = ~st_nxt.cfg.dir
            & (st_nxt.cfg.otype ? ~st_nxt.cfg.out : {CH_N{1'b1}}); // RULE2 RULE16 RULE23
        // pulls would fight an external resistor on open-drain outputs
        st_nxt.pull_en = st_nxt.cfg.pull_en
            & ~(~st_nxt.cfg.dir & {CH_N{st_nxt.cfg.otype}}); // RULE4 RULE5
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= '0;
            // all inputs, latches high, pull-ups on, all masked, push-pull
            st_r.cfg.dir <= DIR_RST; // RULE22
            st_r.cfg.out <= OUT_RST;
            st_r.cfg.pull_sel <= PULL_SEL_RST;
            st_r.cfg.pull_en <= PULL_EN_RST;
            st_r.cfg.invert <= INVERT_RST;
            st_r.cfg.latch <= LATCH_RST;
            st_r.cfg.mask <= MASK_RST;
            st_r.cfg.otype <= OTYPE_RST;
            st_r.pull_en <= PULL_EN_RST;
            st_r.rd_st <= RD_IDLE;
            st_r.rsp.awready <= 1'b1;
            st_r.rsp.wready <= 1'b1;
            st_r.rsp.arready <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register except irq_n_o, which is tied low
    assign axi_rsp_o = st_r.rsp;
    assign gpio_out_o = st_r.cfg.out;
    assign gpio_oe_o = st_r.oe;
    assign pull_en_o = st_r.pull_en;
    assign pull_up_o = st_r.cfg.pull_sel; // RULE3
    // the request only ever pulls low, so boards can share one wire
    assign irq_n_o = 1'b0; // RULE21 RULE25
    assign irq_oe_o = st_r.irq; // RULE25

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_irq_follow;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        irq_oe_o == (|st_r.status);
    endproperty
    a_irq_follow: assert property (p_irq_follow) // RULE19
        else $error("request line does not follow status vector");

    property p_mask;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (st_r.status & st_r.cfg.mask) == '0;
    endproperty
    a_mask: assert property (p_mask) // RULE18
        else $error("masked channel shows interrupt status");

    property p_od_pull;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (pull_en_o & ~st_r.cfg.dir & {CH_N{st_r.cfg.otype}}) == '0;
    endproperty
    a_od_pull: assert property (p_od_pull) // RULE5
        else $error("pull enabled on open-drain output");

    property p_in_no_drive;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (gpio_oe_o & st_r.cfg.dir) == '0;
    endproperty
    a_in_no_drive: assert property (p_in_no_drive) // RULE23
        else $error("input channel drives its terminal");

    property p_od_high;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        st_r.cfg.otype |-> (gpio_oe_o & st_r.cfg.out) == '0;
    endproperty
    a_od_high: assert property (p_od_high) // RULE16
        else $error("open-drain output drives high");

    property p_reset_cfg;
        @(posedge clk_sys_i)
        sys_rst_i |=> (st_r.cfg.dir == DIR_RST && st_r.cfg.out == OUT_RST
            && st_r.cfg.mask == MASK_RST && st_r.cfg.latch == LATCH_RST
            && st_r.cfg.pull_en == PULL_EN_RST && st_r.cfg.otype == OTYPE_RST
            && !irq_oe_o);
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) // RULE22
        else $error("reset configuration wrong");

    property p_read_clears;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        rd_input |=> (st_r.pend == '0) && (st_r.ref_lvl == st_r.rsp.rdata[CH_N-1:0])
            && st_r.rsp.rvalid;
    endproperty
    a_read_clears: assert property (p_read_clears) // RULE14
        else $error("input read did not release all channels");

    property p_latch_capture;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (cap_evt != '0) && !rd_input && !wr_go
            |=> ((st_r.pend & $past(cap_evt)) == $past(cap_evt))
            && ((st_r.cap & $past(cap_evt)) == ($past(seen) & $past(cap_evt)));
    endproperty
    a_latch_capture: assert property (p_latch_capture) // RULE11
        else $error("latched change not captured");

    property p_write_answer;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_go |=> st_r.rsp.bvalid ##0 !st_r.rsp.awready ##0 !st_r.rsp.wready;
    endproperty
    a_write_answer: assert property (p_write_answer) // RULE20
        else $error("write not answered one cycle later");

    property p_read_answer;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        rd_go |=> st_r.rsp.rvalid && !st_r.rsp.arready;
    endproperty
    a_read_answer: assert property (p_read_answer) // RULE1
        else $error("read not answered one cycle later");

endmodule : gpiol_top

// [shared/gpiol_pkg.sv]
// gpiol_pkg: constants, register map and carrier types of the eight-channel
// latched-interrupt gpio port.
// assumes an axi4-lite master with 32-bit data and a single 100 MHz clock.
package gpiol_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int CH_N = 8;        // channels in the port
    localparam int AXI_AW = 6;      // byte address width of the register window
    localparam int AXI_DW = 32;     // axi data width
    localparam int AXI_SW = 4;      // write strobe width
    localparam int IDX_LSB = 2;     // word index starts above the byte lanes
    localparam int BYTE0 = 0;       // strobe lane that holds the channel byte

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [AXI_AW-1:0] ADDR_INPUT = 6'h00;    // ro, read clears status
    localparam logic [AXI_AW-1:0] ADDR_OUTPUT = 6'h04;   // rw, output latch
    localparam logic [AXI_AW-1:0] ADDR_DIR = 6'h08;      // rw, 0 out / 1 in
    localparam logic [AXI_AW-1:0] ADDR_PULL_SEL = 6'h0C; // rw, 0 down / 1 up
    localparam logic [AXI_AW-1:0] ADDR_PULL_EN = 6'h10;  // rw, 0 off / 1 on
    localparam logic [AXI_AW-1:0] ADDR_INVERT = 6'h14;   // rw, input polarity
    localparam logic [AXI_AW-1:0] ADDR_LATCH = 6'h18;    // rw, input capture mode
    localparam logic [AXI_AW-1:0] ADDR_OTYPE = 6'h1C;    // rw, bit 0 port-wide
    localparam logic [AXI_AW-1:0] ADDR_MASK = 6'h20;     // rw, 1 masks channel
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 6'h24;   // ro, interrupt status
    localparam int OTYPE_BIT = 0;                        // output type field

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [CH_N-1:0] DIR_RST = 8'hFF;
    localparam logic [CH_N-1:0] OUT_RST = 8'hFF;
    localparam logic [CH_N-1:0] PULL_SEL_RST = 8'hFF;
    localparam logic [CH_N-1:0] PULL_EN_RST = 8'hFF;
    localparam logic [CH_N-1:0] INVERT_RST = 8'h00;
    localparam logic [CH_N-1:0] LATCH_RST = 8'h00;
    localparam logic [CH_N-1:0] MASK_RST = 8'hFF;
    localparam logic OTYPE_RST = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic [AXI_AW-1:0] awaddr;
        logic awvalid;
        logic [AXI_DW-1:0] wdata;
        logic [AXI_SW-1:0] wstrb;
        logic wvalid;
        logic bready;
        logic [AXI_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } gpiol_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [AXI_DW-1:0] rdata;
    } gpiol_axi_rsp_t;

    // port settings, selected by the register address
    typedef struct packed {
        logic [CH_N-1:0] dir;
        logic [CH_N-1:0] out;
        logic [CH_N-1:0] pull_sel;
        logic [CH_N-1:0] pull_en;
        logic [CH_N-1:0] invert;
        logic [CH_N-1:0] latch;
        logic [CH_N-1:0] mask;
        logic otype;
    } gpiol_cfg_t;

    typedef enum logic {RD_IDLE, RD_BUSY} gpiol_rd_t;

endpackage : gpiol_pkg

// [verif/gpiol_pins.sv]
// gpiol_pins: terminal and shared request wire model for the gpio port.
// assumes the bench drives an external source per channel and a second board.
`timescale 1ns/100ps
module gpiol_pins
    import gpiol_pkg::*;
(
    // clock
    input wire logic clk_sys_i,
    // port side
    input wire logic [CH_N-1:0] gpio_out_i,
    input wire logic [CH_N-1:0] gpio_oe_i,
    input wire logic [CH_N-1:0] pull_en_i,
    input wire logic [CH_N-1:0] pull_up_i,
    input wire logic irq_oe_i,
    // bench side
    input wire logic [CH_N-1:0] ext_lvl_i,
    input wire logic [CH_N-1:0] ext_en_i,
    input wire logic other_oe_i,
    // resolved levels
    output logic [CH_N-1:0] pin_o,
    output logic irq_wire_o
);
    logic [CH_N-1:0] last_r; // floating pins drift away from this level
    ////////////////////////////////////////////////////////////////////////
    // port drive wins, then the outside source, then the pull resistor
    always_comb
    begin
        for (int i = 0; i < CH_N; i++)
            pin_o[i] = gpio_oe_i[i] ? gpio_out_i[i] : ext_en_i[i] ? ext_lvl_i[i] :
                pull_en_i[i] ? pull_up_i[i] : ~last_r[i];
    end
    always_ff @(posedge clk_sys_i) last_r <= pin_o;
    // wired request: any board pulling makes the wire low
    assign irq_wire_o = ~(irq_oe_i | other_oe_i);
endmodule : gpiol_pins

// [verif/tb_top.sv]
// tb_top: self-checking bench of the gpio port over axi4-lite.
// assumes gpiol_pins models the terminals and the shared request wire.
`timescale 1ns/100ps
module tb_top;
    import gpiol_pkg::*;
    logic clk = 0, rst = 1, oth = 0; // clock, reset, other board pulling
    logic [7:0] ext = 0, ext_en = 8'hFF, pin, v; // outside source and pins
    logic irqw, irq_n, irq_oe; // request wire and port
    logic [7:0] g_out, g_oe, p_en, p_up; // port terminal outputs
    gpiol_axi_req_t req = '0; // bus requests
    gpiol_axi_rsp_t rsp; // bus answers
    logic [33:0] q[$]; // expected resp and data
    logic [7:0] rst_v[10] = '{8'h0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0, 8'h0, 8'h0, 8'hFF, 8'h0};
    int n_mismatch = 0, check_count = 0, cyc = 0, seed = 32'h785c;
    always #5 clk = ~clk;
    gpiol_top gpiol_top_inst (.clk_sys_i(clk), .sys_rst_i(rst), .axi_req_i(req),
        .axi_rsp_o(rsp), .gpio_in_i(pin), .gpio_out_o(g_out), .gpio_oe_o(g_oe),
        .pull_en_o(p_en), .pull_up_o(p_up), .irq_n_o(irq_n), .irq_oe_o(irq_oe));
    gpiol_pins gpiol_pins_inst (.clk_sys_i(clk), .gpio_out_i(g_out), .gpio_oe_i(g_oe),
        .pull_en_i(p_en), .pull_up_i(p_up), .irq_oe_i(irq_oe), .ext_lvl_i(ext),
        .ext_en_i(ext_en), .other_oe_i(oth), .pin_o(pin), .irq_wire_o(irqw));
    ////////////////////////////////////////////////////////////////////////
    // comparison, verdict and hang guard
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // answer watcher takes the oldest note as each answer appears
    always @(posedge clk)
    begin
        if (rsp.rvalid && req.rready)
        begin
            chk(rsp.rdata, q[0][31:0]);
            chk(32'(rsp.rresp), 32'(q.pop_front() >> 32));
        end
        if (rsp.bvalid && req.bready)
            chk(32'(rsp.bresp), 32'(q.pop_front() >> 32));
    end
    ////////////////////////////////////////////////////////////////////////
    // bus cycles: hold each channel until taken, then wait the answer
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        q.push_back({RESP_OKAY, 32'h0});
        req.awaddr <= a;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hF;
        req.awvalid <= 1;
        req.wvalid <= 1;
        req.bready <= 1;
        do
        begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 0;
            if (rsp.wready) req.wvalid <= 0;
        end while (!rsp.bvalid);
        req.bready <= 0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge clk);
        q.push_back({r, 24'h0, d});
        req.araddr <= a;
        req.arvalid <= 1;
        req.rready <= 1;
        do
        begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 0;
        end while (!rsp.rvalid);
        req.rready <= 0;
    endtask : rd
    task automatic w8;
        repeat (8) @(posedge clk);
    endtask : w8
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        for (int i = 1; i < 10; i++) rd(6'(4 * i), rst_v[i], RESP_OKAY);
        rd(6'h28, 8'h0, RESP_SLVERR);
        chk(32'(irq_n), 0);
        chk(32'(g_out), 32'hFF);
        chk(32'(g_oe), 0);
        chk(32'(p_en), 32'hFF);
        chk(32'(p_up), 32'hFF);
        $display("reset values done");
        for (int i = 3; i < 7; i++)
        begin
            v = 8'($random(seed));
            wr(6'(4 * i), v);
            rd(6'(4 * i), v, RESP_OKAY);
            if (i == 3) chk(32'(p_up), 32'(v));
            if (i == 4) chk(32'(p_en), 32'(v));
        end
        wr(ADDR_PULL_EN, 8'hFF);
        wr(ADDR_INVERT, 8'h0);
        wr(ADDR_LATCH, 8'h0);
        wr(ADDR_MASK, 8'h0);
        w8();
        rd(ADDR_INPUT, 8'h0, RESP_OKAY);
        ext <= 8'h08;
        w8();
        rd(ADDR_STATUS, 8'h08, RESP_OKAY);
        chk(32'(irq_oe), 1);
        chk(32'(irqw), 0);
        rd(ADDR_INPUT, 8'h08, RESP_OKAY);
        rd(ADDR_STATUS, 8'h0, RESP_OKAY);
        chk(32'(irq_oe), 0);
        oth <= 1;
        w8();
        chk(32'(irqw), 0);
        oth <= 0;
        ext <= 8'h0;
        w8();
        ext <= 8'h08;
        w8();
        rd(ADDR_STATUS, 8'h0, RESP_OKAY);
        wr(ADDR_MASK, 8'hFF);
        ext <= 8'h0;
        w8();
        rd(ADDR_STATUS, 8'h0, RESP_OKAY);
        rd(ADDR_INPUT, 8'h0, RESP_OKAY);
        $display("transparent done");
        wr(ADDR_MASK, 8'h0);
        wr(ADDR_LATCH, 8'hFF);
        ext <= 8'h20;
        w8();
        ext <= 8'h0;
        w8();
        rd(ADDR_STATUS, 8'h20, RESP_OKAY);
        rd(ADDR_INPUT, 8'h20, RESP_OKAY);
        w8();
        rd(ADDR_INPUT, 8'h0, RESP_OKAY);
        rd(ADDR_STATUS, 8'h0, RESP_OKAY);
        $display("latched done");
        wr(ADDR_LATCH, 8'h0);
        wr(ADDR_INVERT, 8'h01);
        w8();
        rd(ADDR_INPUT, 8'h01, RESP_OKAY);
        wr(ADDR_INVERT, 8'h0);
        wr(ADDR_MASK, 8'hFF);
        wr(ADDR_OUTPUT, 8'h05);
        w8();
        chk(32'(g_oe), 0);
        chk(32'(g_out), 32'h05);
        wr(ADDR_OTYPE, 8'h0);
        ext_en <= 8'hF0;
        wr(ADDR_DIR, 8'hF0);
        w8();
        chk(32'(g_oe), 32'h0F);
        rd(ADDR_INPUT, 8'h05, RESP_OKAY);
        wr(ADDR_OTYPE, 8'h01);
        w8();
        chk(32'(g_oe), 32'h0A);
        chk(32'(p_en), 32'hF0);
        $display("outputs done");
        end_sim();
    end
endmodule : tb_top
